/* File: common/evm_params.svh */
// Constants for the exception vector mapper: vector numbers, addresses and bus codes.
`ifndef EVM_PARAMS_SVH
`define EVM_PARAMS_SVH

`define EVM_VEC_BUS_ERR    8'h02
`define EVM_VEC_ADDR_ERR   8'h03
`define EVM_VEC_ILLEGAL    8'h04
`define EVM_VEC_ZERO_DIV   8'h05
`define EVM_VEC_BOUNDS     8'h06
`define EVM_VEC_OVF_TRAP   8'h07
`define EVM_VEC_PRIV       8'h08
`define EVM_VEC_TRACE      8'h09
`define EVM_VEC_LINE_A     8'h0A
`define EVM_VEC_LINE_F     8'h0B
`define EVM_VEC_FORMAT_ERR 8'h0E
`define EVM_VEC_UNINIT     8'h0F
`define EVM_VEC_SPURIOUS   8'h18
`define EVM_VEC_TRAP_BASE  8'h20
`define EVM_VEC_USER_BASE  8'h40

`define EVM_RST_SSP_ADDR   24'h000000
`define EVM_RST_PC_ADDR    24'h000004
`define EVM_RST_WORDS      2'h3
`define EVM_FC_SUP_PROG    3'h6
`define EVM_FC_NONE        3'h0

`endif

/* File: common/evm_pkg.sv */
// Types and shared decoding for the exception vector mapper.
package evm_pkg;

  // Exception sources presented to the mapper.
  typedef enum logic [3:0] {
    EVM_SRC_BUS_ERR    = 4'h0,
    EVM_SRC_ADDR_ERR   = 4'h1,
    EVM_SRC_ILLEGAL    = 4'h2,
    EVM_SRC_ZERO_DIV   = 4'h3,
    EVM_SRC_BOUNDS     = 4'h4,
    EVM_SRC_OVF_TRAP   = 4'h5,
    EVM_SRC_PRIV       = 4'h6,
    EVM_SRC_TRACE      = 4'h7,
    EVM_SRC_LINE_A     = 4'h8,
    EVM_SRC_LINE_F     = 4'h9,
    EVM_SRC_FORMAT_ERR = 4'hA,
    EVM_SRC_TRAP       = 4'hB,
    EVM_SRC_AUTOVEC    = 4'hC,
    EVM_SRC_INT_VEC    = 4'hD,
    EVM_SRC_SPURIOUS   = 4'hE
  } evm_src_t;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    EVM_ST_FETCH = 3'h1,
    EVM_ST_IDLE  = 3'h2,
    EVM_ST_IACK  = 3'h4
  } evm_state_t;

  // Vector table byte address of a vector number.
  function automatic logic [9:0] evm_vec_addr(input logic [7:0] num);
    return {num, 2'b00};
  endfunction

endpackage

/* File: common/evm_map_if.sv */
// Interface between the sequencer and the vector decoder.
`timescale 1ns/1ps
interface evm_map_if;
  import evm_pkg::*;
  evm_src_t   src;
  logic [3:0] arg;
  logic       fmt_en;
  logic [7:0] iack_vec;
  logic       iack_berr;
  logic [7:0] num;
  logic       legal;

  modport seq (output src, arg, fmt_en, iack_vec, iack_berr, input num, legal);
  modport map (input src, arg, fmt_en, iack_vec, iack_berr, output num, legal);
endinterface

/* File: design/evm_vec_decode.sv */
// Combinational decoder from exception source to vector number.
`timescale 1ns/1ps
`include "evm_params.svh"
module evm_vec_decode
  import evm_pkg::*;
(
  evm_map_if.map m
);

  // Decodes the source and its operand into a vector number and a legality flag.
  always_comb begin
    m.num   = `EVM_VEC_ILLEGAL;
    m.legal = 1'b1;
    case (m.src)
      EVM_SRC_BUS_ERR:  m.num = `EVM_VEC_BUS_ERR;
      EVM_SRC_ADDR_ERR: m.num = `EVM_VEC_ADDR_ERR;
      EVM_SRC_ILLEGAL:  m.num = `EVM_VEC_ILLEGAL;
      EVM_SRC_ZERO_DIV: m.num = `EVM_VEC_ZERO_DIV;
      EVM_SRC_BOUNDS:   m.num = `EVM_VEC_BOUNDS;
      EVM_SRC_OVF_TRAP: m.num = `EVM_VEC_OVF_TRAP;
      EVM_SRC_PRIV:     m.num = `EVM_VEC_PRIV;
      EVM_SRC_TRACE:    m.num = `EVM_VEC_TRACE;
      EVM_SRC_LINE_A:   m.num = `EVM_VEC_LINE_A;
      EVM_SRC_LINE_F:   m.num = `EVM_VEC_LINE_F;
      EVM_SRC_FORMAT_ERR: begin
        m.num   = `EVM_VEC_FORMAT_ERR;
        m.legal = m.fmt_en;
      end
      EVM_SRC_TRAP: m.num = `EVM_VEC_TRAP_BASE + {4'h0, m.arg};
      EVM_SRC_AUTOVEC: begin
        m.num   = `EVM_VEC_SPURIOUS + {5'h00, m.arg[2:0]};
        m.legal = (m.arg[2:0] != 3'h0);
      end
      EVM_SRC_INT_VEC: begin
        if (m.iack_berr) begin
          m.num = `EVM_VEC_SPURIOUS;
        end else if (m.iack_vec < `EVM_VEC_USER_BASE) begin
          m.num = `EVM_VEC_UNINIT;
        end else begin
          m.num = m.iack_vec;
        end
      end
      EVM_SRC_SPURIOUS: m.num = `EVM_VEC_SPURIOUS;
      default: m.legal = 1'b0;
    endcase
  end

endmodule

/* File: design/evm_top.sv */
// Exception vector mapper: reset vector fetch and exception-to-vector sequencing.
`timescale 1ns/1ps
`include "evm_params.svh"
module evm_top
  import evm_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_fmt_variant,
  input  wire logic        i_exc_valid,
  input  wire logic [3:0]  i_exc_src,
  input  wire logic [3:0]  i_exc_arg,
  output logic             o_exc_ready,
  input  wire logic        i_bus_ack,
  input  wire logic [15:0] i_bus_data,
  output logic             o_bus_req,
  output logic [23:0]      o_bus_addr,
  output logic [2:0]       o_bus_fc,
  output logic [31:0]      o_ssp,
  output logic [31:0]      o_pc,
  output logic             o_boot_done,
  output logic             o_iack_req,
  output logic [2:0]       o_iack_level,
  input  wire logic        i_iack_done,
  input  wire logic        i_iack_berr,
  input  wire logic [7:0]  i_iack_vec,
  output logic             o_vec_valid,
  output logic [7:0]       o_vec_num,
  output logic [9:0]       o_vec_addr
);

  evm_state_t  state_r, state_nxt;
  logic [1:0]  wcnt_r, wcnt_nxt;
  logic        bus_req_r, bus_req_nxt;
  logic [23:0] bus_addr_r, bus_addr_nxt;
  logic [2:0]  bus_fc_r, bus_fc_nxt;
  logic [31:0] ssp_r, ssp_nxt;
  logic [31:0] pc_r, pc_nxt;
  logic        boot_done_r, boot_done_nxt;
  logic        iack_req_r, iack_req_nxt;
  logic [2:0]  iack_level_r, iack_level_nxt;
  logic        vec_valid_r, vec_valid_nxt;
  logic [7:0]  vec_num_r, vec_num_nxt;
  logic [9:0]  vec_addr_r, vec_addr_nxt;
  logic        ready_r, ready_nxt;
  logic        take;

  evm_map_if map_if ();

  // Decoder sees the pending acknowledge while waiting, else the new request.
  assign map_if.src       = (state_r == EVM_ST_IACK) ? EVM_SRC_INT_VEC : evm_src_t'(i_exc_src);
  assign map_if.arg       = i_exc_arg;
  assign map_if.fmt_en    = i_fmt_variant;
  assign map_if.iack_vec  = i_iack_vec;
  assign map_if.iack_berr = i_iack_berr;

  evm_vec_decode u_decode (
    .m (map_if.map)
  );

  // A request is only taken while idle; otherwise it is ignored.
  assign take = i_exc_valid && (state_r == EVM_ST_IDLE);

  // Next-state logic for the sequencer, the reset fetch and the vector output.
  always_comb begin
    state_nxt      = state_r;
    wcnt_nxt       = wcnt_r;
    bus_req_nxt    = bus_req_r;
    bus_addr_nxt   = bus_addr_r;
    bus_fc_nxt     = bus_fc_r;
    ssp_nxt        = ssp_r;
    pc_nxt         = pc_r;
    boot_done_nxt  = boot_done_r;
    iack_req_nxt   = iack_req_r;
    iack_level_nxt = iack_level_r;
    vec_valid_nxt  = 1'b0;
    vec_num_nxt    = vec_num_r;
    vec_addr_nxt   = vec_addr_r;
    case (state_r)
      EVM_ST_FETCH: begin
        bus_req_nxt = 1'b1;
        bus_fc_nxt  = `EVM_FC_SUP_PROG;
        if (bus_req_r && i_bus_ack) begin
          // four reset words, high word first
          case (wcnt_r)
            2'h0:    ssp_nxt[31:16] = i_bus_data;
            2'h1:    ssp_nxt[15:0]  = i_bus_data;
            2'h2:    pc_nxt[31:16]  = i_bus_data;
            default: pc_nxt[15:0]   = i_bus_data;
          endcase
          wcnt_nxt     = wcnt_r + 2'h1;
          bus_addr_nxt = bus_addr_r + 24'h000002;
          if (wcnt_r == `EVM_RST_WORDS) begin
            bus_req_nxt   = 1'b0;
            bus_fc_nxt    = `EVM_FC_NONE;
            bus_addr_nxt  = `EVM_RST_SSP_ADDR;
            boot_done_nxt = 1'b1;
            state_nxt     = EVM_ST_IDLE;
          end
        end
      end
      EVM_ST_IDLE: begin
        if (take && (i_exc_src == EVM_SRC_INT_VEC)) begin
          iack_req_nxt   = 1'b1;
          iack_level_nxt = i_exc_arg[2:0];
          state_nxt      = EVM_ST_IACK;
        end else if (take && map_if.legal) begin
          vec_valid_nxt = 1'b1;
          vec_num_nxt   = map_if.num;
          vec_addr_nxt  = evm_vec_addr(map_if.num);
        end
      end
      EVM_ST_IACK: begin
        if (i_iack_done) begin
          iack_req_nxt  = 1'b0;
          vec_valid_nxt = 1'b1;
          vec_num_nxt   = map_if.num;
          vec_addr_nxt  = evm_vec_addr(map_if.num);
          state_nxt     = EVM_ST_IDLE;
        end
      end
      default: state_nxt = EVM_ST_FETCH;
    endcase
    ready_nxt = (state_nxt == EVM_ST_IDLE);
  end

  // Registers of the sequencer; reset restarts the vector fetch.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_r      <= EVM_ST_FETCH;
      wcnt_r       <= 2'h0;
      bus_req_r    <= 1'b0;
      bus_addr_r   <= `EVM_RST_SSP_ADDR;
      bus_fc_r     <= `EVM_FC_NONE;
      ssp_r        <= 32'h00000000;
      pc_r         <= 32'h00000000;
      boot_done_r  <= 1'b0;
      iack_req_r   <= 1'b0;
      iack_level_r <= 3'h0;
      vec_valid_r  <= 1'b0;
      vec_num_r    <= 8'h00;
      vec_addr_r   <= 10'h000;
      ready_r      <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      wcnt_r       <= wcnt_nxt;
      bus_req_r    <= bus_req_nxt;
      bus_addr_r   <= bus_addr_nxt;
      bus_fc_r     <= bus_fc_nxt;
      ssp_r        <= ssp_nxt;
      pc_r         <= pc_nxt;
      boot_done_r  <= boot_done_nxt;
      iack_req_r   <= iack_req_nxt;
      iack_level_r <= iack_level_nxt;
      vec_valid_r  <= vec_valid_nxt;
      vec_num_r    <= vec_num_nxt;
      vec_addr_r   <= vec_addr_nxt;
      ready_r      <= ready_nxt;
    end
  end

  // Outputs come straight from the registers.
  assign o_exc_ready  = ready_r;
  assign o_bus_req    = bus_req_r;
  assign o_bus_addr   = bus_addr_r;
  assign o_bus_fc     = bus_fc_r;
  assign o_ssp        = ssp_r;
  assign o_pc         = pc_r;
  assign o_boot_done  = boot_done_r;
  assign o_iack_req   = iack_req_r;
  assign o_iack_level = iack_level_r;
  assign o_vec_valid  = vec_valid_r;
  assign o_vec_num    = vec_num_r;
  assign o_vec_addr   = vec_addr_r;

  // Checks on the mapping and the reset fetch.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  chk_addr_times4: assert property (
    o_vec_valid |-> (o_vec_addr == {o_vec_num, 2'b00}) && (o_vec_num > 8'h01))
    else $error("vector address is not four times the number");
  chk_boot_window: assert property (
    o_bus_req |-> (o_bus_addr < 24'h000008) && !o_boot_done)
    else $error("reset fetch outside the four-word vector");
  chk_pc_low_load: assert property (
    (o_bus_req && i_bus_ack && o_bus_addr == 24'h000006) |=> o_pc[15:0] == $past(i_bus_data)
      && o_boot_done)
    else $error("program counter low word not loaded last");
  chk_boot_space: assert property (
    o_bus_req |-> o_bus_fc == `EVM_FC_SUP_PROG)
    else $error("reset fetch not in supervisor program space");
  chk_iack_spurious: assert property (
    (o_iack_req && i_iack_done && i_iack_berr) |=> o_vec_valid && o_vec_addr == 10'h060)
    else $error("acknowledge bus error did not take vector 24");
  chk_trap_vector: assert property (
    (take && i_exc_src == EVM_SRC_TRAP) |=> o_vec_valid && o_vec_num == 8'h20 + $past(i_exc_arg))
    else $error("trap vector is not 32 plus operand");
  chk_autovec_level: assert property (
    (take && i_exc_src == EVM_SRC_AUTOVEC && i_exc_arg[2:0] != 3'h0) |=>
      o_vec_valid && o_vec_num == 8'h18 + {5'h00, $past(i_exc_arg[2:0])})
    else $error("autovector is not 24 plus level");
  chk_format_gate: assert property (
    (take && i_exc_src == EVM_SRC_FORMAT_ERR) |=> o_vec_valid == $past(i_fmt_variant))
    else $error("format error vector raised on wrong variant");
  chk_user_vector: assert property (
    (o_iack_req && i_iack_done && !i_iack_berr) |=>
      o_vec_valid && (o_vec_num >= 8'h40 || o_vec_num == 8'h0F) && !o_iack_req)
    else $error("vectored interrupt outside user range");
  chk_fixed_bus_err: assert property (
    (take && i_exc_src == EVM_SRC_BUS_ERR) |=> o_vec_valid && o_vec_num == 8'h02)
    else $error("bus error did not take vector 2");

  cov_boot_done: cover property ($rose(o_boot_done));
  cov_spurious: cover property (o_iack_req && i_iack_done && i_iack_berr);
  cov_user_vec: cover property (o_vec_valid && o_vec_num >= 8'h40);
  cov_trap_top: cover property (o_vec_valid && o_vec_num == 8'h2F);

endmodule

/* File: dv/evm_bus_partner.sv */
// Behavioural model of the boot memory and the interrupting peripherals.
`timescale 1ns/1ps
module evm_bus_partner (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_bus_req,
  input  wire logic [23:0] i_bus_addr,
  input  wire logic        i_iack_req,
  input  wire logic [3:0]  i_delay,
  input  wire logic [7:0]  i_vec,
  input  wire logic        i_berr,
  output logic             o_bus_ack = 1'b0,
  output logic [15:0]      o_bus_data = 16'h0000,
  output logic             o_iack_done = 1'b0,
  output logic             o_iack_berr = 1'b0,
  output logic [7:0]       o_iack_vec = 8'h00
);
  logic [3:0] wait_r = 4'h0;

  // Waits i_delay cycles, then answers the pending request for one cycle.
  always @(posedge i_clk_sys) begin
    o_bus_ack   <= 1'b0;
    o_iack_done <= 1'b0;
    o_iack_berr <= 1'b0;
    o_bus_data  <= ~o_bus_data; // Released lines never keep the last value.
    o_iack_vec  <= ~o_iack_vec;
    if (i_reset || !(i_bus_req || i_iack_req) || o_bus_ack || o_iack_done) begin
      wait_r <= 4'h0;
    end else if (wait_r < i_delay) begin
      wait_r <= wait_r + 4'h1;
    end else if (i_bus_req) begin
      o_bus_ack  <= 1'b1;
      o_bus_data <= {i_bus_addr[7:0], 8'hC3};
    end else begin
      o_iack_done <= 1'b1;
      o_iack_berr <= i_berr;
      o_iack_vec  <= i_vec;
    end
  end
endmodule

/* File: dv/exception_vector_mapper_test.sv */
// Self-checking bench for the exception vector mapper.
`timescale 1ns/1ps
`include "evm_params.svh"
module exception_vector_mapper_test;
  import evm_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        fmt_variant = 1'b0;
  logic        exc_valid = 1'b0;
  logic [3:0]  exc_src = 4'h0;
  logic [3:0]  exc_arg = 4'h0;
  logic [3:0]  delay = 4'h0;
  logic [7:0]  pvec = 8'h40;
  logic        pberr = 1'b0;
  logic        exc_ready, bus_req, bus_ack, boot_done, iack_req, iack_done, iack_berr, vec_valid;
  logic [15:0] bus_data;
  logic [23:0] bus_addr;
  logic [2:0]  bus_fc, iack_level;
  logic [31:0] supervisor_stack_pointer, pc;
  logic [7:0]  iack_vec, vec_num, e;
  logic [9:0]  vec_addr;
  logic [7:0]  exp_q[$];
  logic [3:0]  ra;
  int          errors = 0;
  int          compares = 0;
  int          words = 0;
  int          seed = 32'hb78976a9;

  evm_top u_dut (.i_clk_sys(clk_sys), .i_reset(reset), .i_fmt_variant(fmt_variant),
    .i_exc_valid(exc_valid), .i_exc_src(exc_src), .i_exc_arg(exc_arg), .o_exc_ready(exc_ready),
    .i_bus_ack(bus_ack), .i_bus_data(bus_data), .o_bus_req(bus_req), .o_bus_addr(bus_addr),
    .o_bus_fc(bus_fc), .o_ssp(supervisor_stack_pointer), .o_pc(pc), .o_boot_done(boot_done), .o_iack_req(iack_req),
    .o_iack_level(iack_level), .i_iack_done(iack_done), .i_iack_berr(iack_berr),
    .i_iack_vec(iack_vec), .o_vec_valid(vec_valid), .o_vec_num(vec_num), .o_vec_addr(vec_addr));

  evm_bus_partner u_partner (.i_clk_sys(clk_sys), .i_reset(reset), .i_bus_req(bus_req),
    .i_bus_addr(bus_addr), .i_iack_req(iack_req), .i_delay(delay), .i_vec(pvec),
    .i_berr(pberr), .o_bus_ack(bus_ack), .o_bus_data(bus_data), .o_iack_done(iack_done),
    .o_iack_berr(iack_berr), .o_iack_vec(iack_vec));

  // Free-running system clock.
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watches boot reads and vector pulses against the noted expectations.
  always @(posedge clk_sys) begin
    if (reset) begin
      words <= 0;
    end else if (bus_req && bus_ack) begin
      check(bus_addr === 24'(2 * words) && bus_fc === `EVM_FC_SUP_PROG, "boot read");
      words <= words + 1;
    end
    // A pulse launched just before a reset is still compared.
    if (vec_valid === 1'b1 && exp_q.size() == 0) begin
      check(1'b0, "unexpected vector");
    end else if (vec_valid === 1'b1) begin
      e = exp_q.pop_front();
      check(vec_num === e && vec_addr === {e, 2'b00}, "vector number or address");
    end
  end

  // Holds reset for ten cycles, then waits for the four boot words.
  task automatic boot(input logic [3:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    delay <= d;
    exc_valid <= 1'b0;
    reset <= 1'b1;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    while (boot_done !== 1'b1 && n < 300) begin
      n++;
      @(posedge clk_sys);
    end
    check(words == 4 && supervisor_stack_pointer === 32'h00C3_02C3 && pc === 32'h04C3_06C3, "boot words");
    check(bus_req === 1'b0 && bus_fc === `EVM_FC_NONE, "boot bus release");
    $display("test boot done");
  endtask

  // Presents one request once ready is seen; exp below zero means no vector.
  task automatic send(input logic [3:0] src, input logic [3:0] arg, input int exp);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (exc_ready !== 1'b1 && n < 200) begin
      n++;
      @(posedge clk_sys);
    end
    exc_valid <= 1'b1;
    exc_src   <= src;
    exc_arg   <= arg;
    if (exp >= 0) exp_q.push_back(8'(exp));
  endtask

  // Vectored interrupt with a refused request during the acknowledge.
  task automatic vint(input logic [2:0] lvl, input logic [7:0] v, input logic be, input int exp);
    int n;
    n = 0;
    send(4'hD, {1'b0, lvl}, exp);
    @(posedge clk_sys);
    exc_src <= 4'h0;
    pvec    <= v;
    pberr   <= be;
    delay   <= 4'($random(seed) & 3);
    @(posedge clk_sys);
    check(iack_req === 1'b1 && iack_level === lvl && exc_ready === 1'b0, "acknowledge start");
    exc_valid <= 1'b0;
    while (exc_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk_sys);
    end
    check(iack_req === 1'b0, "acknowledge end");
  endtask

  // Main sequence.
  initial begin
    boot(4'h0);
    for (int s = 0; s < 10; s++) send(4'(s), 4'($random(seed)), s + 2);
    send(4'hA, 4'h0, -1);
    send(4'hE, 4'h0, 24);
    send(4'hF, 4'h0, -1);
    fmt_variant <= 1'b1;
    send(4'hA, 4'h0, 14);
    for (int n = 0; n < 16; n++) send(4'hB, 4'(n), 32 + n);
    for (int l = 0; l < 8; l++) send(4'hC, 4'(l), l == 0 ? -1 : 24 + l);
    for (int r = 0; r < 20; r++) begin
      ra = 4'($random(seed));
      send(4'hB, ra, 32 + ra);
    end
    $display("test fixed vectors done");
    vint(3'h5, 8'h40, 1'b0, 64);
    vint(3'h7, 8'hFF, 1'b0, 255);
    vint(3'h1, 8'h0C, 1'b0, 15);
    vint(3'h2, 8'h30, 1'b0, 15);
    vint(3'h3, 8'h0F, 1'b0, 15);
    vint(3'h4, 8'h80, 1'b1, 24);
    $display("test vectored interrupts done");
    send(4'hB, 4'h1, 33);
    boot(4'h9);
    send(4'hB, 4'hF, 47);
    @(posedge clk_sys);
    exc_valid <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check(exp_q.size() == 0, "missing vector");
    $display("test second reset done");
    complete_run();
  end

  // Cuts a hang short.
  initial begin
    #500000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
endmodule
